// [include/ase_pkg.sv]
// Constants for the accumulator store execution unit.
// Assumes the core supplies opcode bytes, operands and the memory ports.
package ase_pkg;

  // Opcode first bytes
  localparam logic [7:0] ASE_OP_BYTE_PTR   = 8'h92; // Pointer / displacement
  localparam logic [7:0] ASE_OP_SHORT_FE   = 8'h93; // Page FE00H
  localparam logic [7:0] ASE_OP_SHORT_00   = 8'h94; // Page 0000H
  localparam logic [7:0] ASE_OP_SHORT_01   = 8'h95; // Page 0100H
  localparam logic [7:0] ASE_OP_LONG       = 8'h96; // Three-byte direct
  localparam logic [7:0] ASE_OP_WORD_PTR   = 8'h17; // Pair word store

  // Page high bytes of the short direct forms
  localparam logic [7:0] ASE_PAGE_00       = 8'h00;
  localparam logic [7:0] ASE_PAGE_01       = 8'h01;
  localparam logic [7:0] ASE_PAGE_FE       = 8'hFE;

  // Second byte fields
  localparam int         ASE_DISP_FLAG_BIT = 7;     // 1 = displacement form
  localparam int         ASE_INDEX_C_BIT   = 0;     // 1 = C-indexed form
  localparam int         ASE_PTR_LSB       = 1;     // Pointer number bits 6-1
  localparam int         ASE_PTR_W         = 6;     // Pointers 0..63
  localparam int         ASE_DISP_W        = 7;     // Offset -64..63

  // Status word bit copied into the ninth bit
  localparam int         ASE_PARITY_BIT    = 1;

  // Slow region: word stores are split here
  localparam logic [15:0] ASE_SLOW_BASE    = 16'hFE00;

  // Program counter advances
  localparam logic [1:0] ASE_PC_INC_2      = 2'h2;
  localparam logic [1:0] ASE_PC_INC_3      = 2'h3;

  // Store forms
  typedef enum logic [2:0] {
    ASE_K_NONE,   // Not a store this unit executes
    ASE_K_DISP,   // Byte store at pointer 0 + offset
    ASE_K_IND,    // Byte store at pointer n
    ASE_K_SHORT,  // Two-byte direct byte store
    ASE_K_LONG,   // Three-byte direct byte store
    ASE_K_WORD    // Pair word store at pointer n
  } ase_kind_t;

endpackage : ase_pkg

// [rtl/ase_decode.sv]
// Combinational decoder for the store opcodes.
// Assumes first and second opcode bytes are stable while it is read.
`timescale 1ns/1ps
`default_nettype none
module ase_decode
  import ase_pkg::*;
(
  input  wire logic [7:0]  op0_i,      // First opcode byte
  input  wire logic [7:0]  op1_i,      // Second opcode byte
  output ase_kind_t        kind_o,     // Decoded store form
  output logic [1:0]       pc_inc_o,   // Program counter advance
  output logic [7:0]       page_o      // High byte of short direct target
);

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  wire disp_w  = op1_i[ASE_DISP_FLAG_BIT];  // Bit 7 picks the offset form
  wire idx_c_w = op1_i[ASE_INDEX_C_BIT];    // C-indexed forms not ours
  wire is92_w  = (op0_i == ASE_OP_BYTE_PTR);
  wire is17_w  = (op0_i == ASE_OP_WORD_PTR);
  wire short_w = (op0_i == ASE_OP_SHORT_00) || (op0_i == ASE_OP_SHORT_01) ||
                 (op0_i == ASE_OP_SHORT_FE);

  ////////////////////////////////////////////////////////////////////////
  // Form selection
  assign kind_o =
    (is92_w && disp_w)                ? ASE_K_DISP  :
    (is92_w && !idx_c_w)              ? ASE_K_IND   :
    (is17_w && !disp_w && !idx_c_w)   ? ASE_K_WORD  :
    short_w                           ? ASE_K_SHORT :
    (op0_i == ASE_OP_LONG)            ? ASE_K_LONG  :
                                        ASE_K_NONE;

  // Only the three-byte direct form moves the counter by three
  assign pc_inc_o = (op0_i == ASE_OP_LONG) ? ASE_PC_INC_3 : ASE_PC_INC_2;

  // Page of the two-byte direct forms
  assign page_o = (op0_i == ASE_OP_SHORT_01) ? ASE_PAGE_01 :
                  (op0_i == ASE_OP_SHORT_FE) ? ASE_PAGE_FE : ASE_PAGE_00;

endmodule : ase_decode
`default_nettype wire

// [rtl/ase_store_exec.sv]
// Execution unit for accumulator byte stores and pair word stores.
// Assumes a pointer read port that answers in the same cycle and a
// memory write port whose targets decide themselves if they hold bit 8.
`timescale 1ns/1ps
`default_nettype none
module ase_store_exec
  import ase_pkg::*;
(
  input  wire logic        mclk_i,       // CPU clock, 200 MHz
  input  wire logic        rst_i,        // Asynchronous reset, high
  input  wire logic        start_i,      // Instruction offered
  input  wire logic [7:0]  op0_i,        // First opcode byte
  input  wire logic [7:0]  op1_i,        // Second opcode byte
  input  wire logic [7:0]  op2_i,        // Third opcode byte
  input  wire logic [7:0]  acc_i,        // Accumulator
  input  wire logic [7:0]  breg_i,       // Auxiliary B register
  input  wire logic [7:0]  psw_i,        // Program status word
  input  wire logic [15:0] ptr_rdata_i,  // Pointer word, same cycle
  output logic             busy_o,       // Store in progress
  output logic             unsupported_o,// Offered opcode not executed
  output logic             ptr_rd_o,     // Pointer read strobe
  output logic [15:0]      ptr_addr_o,   // Pointer low byte address
  output logic             mem_we_o,     // Write strobe
  output logic             mem_word_o,   // Write both bytes
  output logic [15:0]      mem_addr_o,   // Target address: low byte, high byte in ASE_S_WR_HI
  output logic [15:0]      mem_wdata_o,  // High byte B and low byte data, or 00 and B in ASE_S_WR_HI
  output logic             mem_ninth_o,  // Value for bit 8 of targets
  output logic             done_o,       // Last cycle of the store
  output logic [1:0]       pc_inc_o      // PC advance, valid with done
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Sign-extend the seven-bit offset to the address width
  function automatic logic [15:0] sext_off(input logic [7:0] b);
    sext_off = {{(16 - ASE_DISP_W){b[ASE_DISP_W-1]}}, b[ASE_DISP_W-1:0]};
  endfunction : sext_off

  typedef enum logic [1:0] {
    ASE_S_IDLE,   // Waiting for a store
    ASE_S_PTR,    // Pointer read, or first cycle of long direct
    ASE_S_WR,     // Write cycle (last unless split)
    ASE_S_WR_HI   // High byte of a split word store
  } ase_state_t;

  ase_state_t   state_r;        // Sequencer state
  ase_state_t   state_nxt;      // Its next value
  ase_kind_t    kind_r;         // Form being executed
  logic [15:0]  addr_r;         // Target address
  logic [7:0]   off_r;          // Offset byte (offset form)
  logic [7:0]   acc_r;          // Accumulator captured at start
  logic [7:0]   b_r;            // B captured at start
  logic         ninth_r;        // Parity captured at start
  logic [1:0]   inc_r;          // PC advance
  logic         split_r;        // Word store falls in the slow region

  ase_kind_t    dec_kind;       // Decoder result
  logic [1:0]   dec_inc;        // Decoder PC advance
  logic [7:0]   dec_page;       // Decoder short page

  ase_decode u_dec (
    .op0_i    (op0_i),
    .op1_i    (op1_i),
    .kind_o   (dec_kind),
    .pc_inc_o (dec_inc),
    .page_o   (dec_page)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode and address arithmetic
  wire idle_w   = (state_r == ASE_S_IDLE);
  wire take_w   = start_i && idle_w && (dec_kind != ASE_K_NONE);
  // Pointer 0 for the offset form, n from bits 6-1 otherwise
  wire [ASE_PTR_W-1:0] ptr_n_w = op1_i[ASE_PTR_LSB +: ASE_PTR_W];
  wire [15:0] ptr_addr_w = (dec_kind == ASE_K_DISP) ? 16'h0000 :
                           {9'h000, ptr_n_w, 1'b0};
  // Offset added only for the offset form
  wire [15:0] add_w = (kind_r == ASE_K_DISP) ? sext_off(off_r) :
                                               16'h0000;
  wire [15:0] sum_w = ptr_rdata_i + add_w;
  wire slow_w = (sum_w >= ASE_SLOW_BASE);
  wire last_w = ((state_r == ASE_S_WR) && !split_r) ||
                (state_r == ASE_S_WR_HI);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ASE_S_IDLE: begin
        // Short direct needs no preparation cycle
        if (take_w) begin
          state_nxt = (dec_kind == ASE_K_SHORT) ? ASE_S_WR : ASE_S_PTR;
        end
      end
      ASE_S_PTR: begin
        state_nxt = ASE_S_WR;
      end
      ASE_S_WR: begin
        state_nxt = split_r ? ASE_S_WR_HI : ASE_S_IDLE;
      end
      ASE_S_WR_HI: begin
        state_nxt = ASE_S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ASE_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand capture at acceptance
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      kind_r  <= ASE_K_NONE;
      off_r   <= 8'h00;
      acc_r   <= 8'h00;
      b_r     <= 8'h00;
      ninth_r <= 1'b0;
      inc_r   <= ASE_PC_INC_2;
    end else if (take_w) begin
      kind_r  <= dec_kind;
      off_r   <= op1_i;
      acc_r   <= acc_i;
      b_r     <= breg_i;
      ninth_r <= psw_i[ASE_PARITY_BIT];
      inc_r   <= dec_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target address
  // Pointer forms latch the sum while the pointer is read; a split word
  // store steps to the high byte so both bytes use the same port.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_r  <= 16'h0000;
      split_r <= 1'b0;
    end else if (take_w) begin
      addr_r  <= (dec_kind == ASE_K_SHORT) ? {dec_page, op1_i} :
                                             {op2_i, op1_i};
      split_r <= 1'b0;
    end else if (state_r == ASE_S_PTR && kind_r != ASE_K_LONG) begin
      addr_r  <= sum_w;
      split_r <= (kind_r == ASE_K_WORD) && slow_w;
    end else if (state_r == ASE_S_WR && split_r) begin
      addr_r  <= addr_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // No status word output exists: flags cannot change here.
  assign busy_o        = !idle_w;
  assign unsupported_o = start_i && idle_w &&
                         (dec_kind == ASE_K_NONE);
  assign ptr_rd_o      = (state_r == ASE_S_PTR) && (kind_r != ASE_K_LONG);
  assign ptr_addr_o    = ptr_rd_o ? {9'h000, off_r[ASE_PTR_LSB +: ASE_PTR_W],
                         1'b0} & {16{kind_r != ASE_K_DISP}} : 16'h0000;
  assign mem_we_o      = (state_r == ASE_S_WR) || (state_r == ASE_S_WR_HI);
  assign mem_word_o    = (state_r == ASE_S_WR) && (kind_r == ASE_K_WORD) &&
                         !split_r;
  assign mem_addr_o    = addr_r;
  assign mem_wdata_o   = (state_r == ASE_S_WR_HI) ? {8'h00, b_r} :
                         {b_r, acc_r};
  assign mem_ninth_o   = ninth_r;
  assign done_o        = last_w;
  assign pc_inc_o      = inc_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_write_done;
    mem_we_o && done_o;
  endsequence

  property p_short_one;
    take_w && dec_kind == ASE_K_SHORT |=> s_write_done and
      (mem_addr_o == {$past(dec_page), $past(op1_i)});
  endproperty
  a_short_one: assert property (p_short_one)
    else $error("short direct store not written in one cycle");

  property p_long_two;
    // Address judged in the write cycle, two edges after acceptance
    take_w && dec_kind == ASE_K_LONG |=> !mem_we_o ##1 (s_write_done and
      (mem_addr_o == {$past(op2_i, 2), $past(op1_i, 2)}));
  endproperty
  a_long_two: assert property (p_long_two)
    else $error("long direct store wrong address or timing");

  property p_long_inc;
    take_w && dec_kind == ASE_K_LONG |=> ##1 done_o && pc_inc_o == 2'h3;
  endproperty
  a_long_inc: assert property (p_long_inc)
    else $error("long direct store must advance PC by three");

  property p_ptr_fetch;
    take_w && dec_kind != ASE_K_SHORT && dec_kind != ASE_K_LONG |=>
      ptr_rd_o && ptr_addr_o == $past(ptr_addr_w);
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch)
    else $error("pointer fetched from wrong byte address");

  property p_disp_sum;
    ptr_rd_o && kind_r == ASE_K_DISP |=> mem_we_o && done_o &&
      mem_addr_o == $past(ptr_rdata_i) + sext_off($past(off_r));
  endproperty
  a_disp_sum: assert property (p_disp_sum)
    else $error("offset store address is not pointer plus offset");

  property p_two_cycle;
    take_w && (dec_kind == ASE_K_DISP || dec_kind == ASE_K_IND) |=>
      !done_o ##1 done_o && pc_inc_o == 2'h2 && mem_wdata_o[7:0] ==
      $past(acc_i, 2);
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("pointer byte store not two cycles");

  property p_word_fast;
    ptr_rd_o && kind_r == ASE_K_WORD && !slow_w |=> mem_word_o && done_o;
  endproperty
  a_word_fast: assert property (p_word_fast)
    else $error("word store below FE00H must finish in two cycles");

  property p_word_split;
    ptr_rd_o && kind_r == ASE_K_WORD && slow_w |=>
      (mem_we_o && !mem_word_o && !done_o) ##1
      (s_write_done and mem_addr_o == $past(mem_addr_o) + 16'h0001 &&
       mem_wdata_o[7:0] == b_r);
  endproperty
  a_word_split: assert property (p_word_split)
    else $error("slow word store not split into low then high byte");

  // Parity taken at acceptance and held over the following write cycle;
  // no new store can be accepted before the second edge after this one
  property p_ninth;
    take_w |=> (mem_ninth_o == $past(psw_i[ASE_PARITY_BIT])) ##1
      $stable(mem_ninth_o);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit does not follow status parity");

  property p_c_form;
    start_i && idle_w && op0_i == ASE_OP_WORD_PTR &&
      op1_i[ASE_INDEX_C_BIT] |-> unsupported_o ##1 !busy_o;
  endproperty
  a_c_form: assert property (p_c_form)
    else $error("C-indexed word store taken as plain word store");

endmodule : ase_store_exec
`default_nettype wire

// [tb/accumulator_store_execution_test.sv]
// Self-checking bench for the accumulator store execution unit.
// Assumes the unit wants pointer reads answered in the same cycle; the bench
// stands in for the pointer registers with a small table.
`timescale 1ns/1ps
`default_nettype none
module accumulator_store_execution_test
  import ase_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        mclk_i      = 1'b0;   // 200 MHz clock
  logic        rst_i       = 1'b1;   // Reset held at start
  logic        start_i     = 1'b0;   // Instruction offer
  logic [7:0]  op0_i       = 8'h00;  // Opcode byte 1
  logic [7:0]  op1_i       = 8'h00;  // Opcode byte 2
  logic [7:0]  op2_i       = 8'h00;  // Opcode byte 3
  logic [7:0]  acc_i       = 8'h00;  // Accumulator
  logic [7:0]  breg_i      = 8'h00;  // B register
  logic [7:0]  psw_i       = 8'h00;  // Status word
  logic [15:0] ptr_rdata_i;          // Pointer answer
  logic        busy_o, unsupported_o, ptr_rd_o, mem_we_o, mem_word_o;
  logic        mem_ninth_o, done_o;
  logic [15:0] ptr_addr_o, mem_addr_o, mem_wdata_o;
  logic [1:0]  pc_inc_o;
  logic [15:0] ptr_tab [0:63];       // Pointer registers n
  int          bad_count   = 0;      // Mismatches
  int          comparisons = 0;      // Checks made

  always #2.5 mclk_i = ~mclk_i;

  // Pointer port: outside a read the bus shows a flipped word, so a
  // unit that samples at the wrong time sees rubbish, not a lucky value
  assign ptr_rdata_i = ptr_rd_o ? ptr_tab[ptr_addr_o[6:1]]
                                : ~ptr_tab[ptr_addr_o[6:1]];

  ase_store_exec i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .op0_i(op0_i),
    .op1_i(op1_i), .op2_i(op2_i), .acc_i(acc_i), .breg_i(breg_i),
    .psw_i(psw_i), .ptr_rdata_i(ptr_rdata_i), .busy_o(busy_o),
    .unsupported_o(unsupported_o), .ptr_rd_o(ptr_rd_o),
    .ptr_addr_o(ptr_addr_o), .mem_we_o(mem_we_o), .mem_word_o(mem_word_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ninth_o(mem_ninth_o), .done_o(done_o), .pc_inc_o(pc_inc_o));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic close_out;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////
  // One store: offered at a falling edge, followed until done
  task automatic run(input logic [7:0] o0, o1, o2, a, b, p, input int n,
                     input logic [15:0] ad, input logic [1:0] pc,
                     input logic wd, input logic up,
                     input logic [15:0] pa);
    int   k;
    int   w;
    int   r;
    logic split;
    split = wd && (ad >= ASE_SLOW_BASE);
    op0_i = o0;
    op1_i = o1;
    op2_i = o2;
    acc_i = a;
    breg_i = b;
    psw_i = p;
    start_i = 1'b1;
    w = 0;
    r = 0;
    for (k = 1; k <= 8; k++) begin
      @(negedge mclk_i);
      start_i = 1'b0;
      chk("busy", 16'(busy_o), 16'h0001);
      if (ptr_rd_o === 1'b1) begin
        r++;
        chk("ptr_addr", ptr_addr_o, pa);
      end
      if (mem_we_o === 1'b1) begin
        w++;
        chk("ninth", 16'(mem_ninth_o), 16'(p[ASE_PARITY_BIT]));
        if (w == 1) begin
          chk("addr", mem_addr_o, ad);
          chk("low", 16'(mem_wdata_o[7:0]), 16'(a));
          chk("word", 16'(mem_word_o), 16'(wd && !split));
          if (wd && !split) begin
            chk("high", 16'(mem_wdata_o[15:8]), 16'(b));
          end
        end else begin
          chk("addr2", mem_addr_o, ad + 16'h0001);
          chk("low2", 16'(mem_wdata_o[7:0]), 16'(b));
        end
      end
      if (done_o === 1'b1) break;
    end
    if (k > 8) begin
      bad_count++;
      close_out();
    end
    chk("cycles", 16'(k), 16'(n));
    chk("pc_inc", 16'(pc_inc_o), 16'(pc));
    chk("writes", 16'(w), split ? 16'h0002 : 16'h0001);
    chk("reads", 16'(r), 16'(up));
    @(negedge mclk_i);
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_short;
    run(8'h94, 8'h11, 8'h00, 8'h50, 8'h00, 8'h02, 1, 16'h0011, 2'h2,
        1'b0, 1'b0, 16'h0000);
    run(8'h95, 8'h20, 8'h00, 8'h51, 8'h00, 8'hFD, 1, 16'h0120, 2'h2,
        1'b0, 1'b0, 16'h0000);
    run(8'h93, 8'hFF, 8'h00, 8'hA5, 8'h00, 8'h02, 1, 16'hFEFF, 2'h2,
        1'b0, 1'b0, 16'h0000);
  endtask : t_short

  task automatic t_long;
    run(8'h96, 8'h00, 8'h02, 8'h88, 8'h00, 8'h02, 2, 16'h0200, 2'h3,
        1'b0, 1'b0, 16'h0000);
    run(8'h96, 8'h00, 8'hFF, 8'h89, 8'h00, 8'hFD, 2, 16'hFF00, 2'h3,
        1'b0, 1'b0, 16'h0000);
    run(8'h96, 8'h34, 8'h00, 8'h3C, 8'h00, 8'h02, 2, 16'h0034, 2'h3,
        1'b0, 1'b0, 16'h0000);
  endtask : t_long

  // Offset form around pointer 0 = 0051H, both ends of the range
  task automatic t_offset;
    run(8'h92, 8'h85, 8'h00, 8'h51, 8'h00, 8'h02, 2, 16'h0056, 2'h2,
        1'b0, 1'b1, 16'h0000);
    run(8'h92, 8'hFB, 8'h00, 8'h52, 8'h00, 8'hFD, 2, 16'h004C, 2'h2,
        1'b0, 1'b1, 16'h0000);
    run(8'h92, 8'hC0, 8'h00, 8'h53, 8'h00, 8'h02, 2, 16'h0011, 2'h2,
        1'b0, 1'b1, 16'h0000);
    run(8'h92, 8'hBF, 8'h00, 8'h54, 8'h00, 8'h02, 2, 16'h0090, 2'h2,
        1'b0, 1'b1, 16'h0000);
  endtask : t_offset

  // Pointer byte form and word forms, including the split region
  task automatic t_pointer;
    run(8'h92, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h02, 2, 16'h0055, 2'h2,
        1'b0, 1'b1, 16'h0002);
    run(8'h17, 8'h02, 8'h00, 8'h34, 8'h12, 8'h02, 2, 16'h0055, 2'h2,
        1'b1, 1'b1, 16'h0002);
    run(8'h17, 8'h7C, 8'h00, 8'h78, 8'h56, 8'hFD, 2, 16'hFDFF, 2'h2,
        1'b1, 1'b1, 16'h007C);
    run(8'h17, 8'h7E, 8'h00, 8'h9A, 8'hBC, 8'h02, 3, 16'hFE12, 2'h2,
        1'b1, 1'b1, 16'h007E);
  endtask : t_pointer

  // Forms left to other units are flagged and do nothing
  task automatic t_refused;
    logic [15:0] tab [0:3];
    tab = '{16'h1703, 16'h1782, 16'h9203, 16'h9700};
    foreach (tab[i]) begin
      {op0_i, op1_i} = tab[i];
      start_i = 1'b1;
      #1;
      chk("unsupported", 16'(unsupported_o), 16'h0001);
      @(negedge mclk_i);
      start_i = 1'b0;
      chk("idle", 16'({busy_o, mem_we_o, ptr_rd_o}), 16'h0000);
      @(negedge mclk_i);
    end
  endtask : t_refused

  // Offer held during a long store is ignored; the unit is still busy in
  // its done cycle, so the held offer is taken at the first idle edge
  task automatic t_b2b;
    op0_i = 8'h96;
    op1_i = 8'h00;
    op2_i = 8'h03;
    acc_i = 8'h11;
    start_i = 1'b1;
    @(negedge mclk_i);
    op0_i = 8'h94;
    op1_i = 8'h77;
    acc_i = 8'h22;
    chk("busy_c1", 16'({busy_o, mem_we_o, done_o}), 16'h0004);
    @(negedge mclk_i);
    chk("long_addr", mem_addr_o, 16'h0300);
    chk("long_end", 16'({mem_we_o, done_o}), 16'h0003);
    @(negedge mclk_i);
    chk("b2b_wait", 16'({busy_o, mem_we_o}), 16'h0000);
    @(negedge mclk_i);
    start_i = 1'b0;
    chk("b2b_addr", mem_addr_o, 16'h0077);
    chk("b2b_data", 16'(mem_wdata_o[7:0]), 16'h0022);
    chk("b2b_end", 16'({mem_we_o, done_o, pc_inc_o}), 16'h000E);
    @(negedge mclk_i);
  endtask : t_b2b

  // Reset in mid-store clears strobes and restores the idle values
  task automatic t_reset;
    op0_i = 8'h96; op1_i = 8'h00; op2_i = 8'h04;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    rst_i = 1'b1;
    #1;
    chk("rst_idle", 16'({busy_o, done_o, mem_we_o, ptr_rd_o}), 16'h0000);
    chk("rst_pc", 16'(pc_inc_o), 16'(ASE_PC_INC_2));
    chk("rst_addr", mem_addr_o, 16'h0000);
    @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    chk("rst_quiet", 16'({busy_o, mem_we_o}), 16'h0000);
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    foreach (ptr_tab[i]) ptr_tab[i] = 16'h0100 + 16'(i);
    ptr_tab[0]  = 16'h0051;
    ptr_tab[1]  = 16'h0055;
    ptr_tab[62] = 16'hFDFF;
    ptr_tab[63] = 16'hFE12;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    t_short();
    t_long();
    t_offset();
    t_pointer();
    t_refused();
    t_b2b();
    t_reset();
    t_short();
    close_out();
  end
endmodule : accumulator_store_execution_test
`default_nettype wire
